// file: rtl/uadc_pkg.sv
// package with constants and carrier types for the usb attach and detach control
package uadc_pkg;

    // ****************************************
    // pin map and timing
    // ****************************************
    localparam int PIN_COUNT = 16;
    localparam int PIN_SEL_W = 4;
    localparam logic [3:0] VBUS_PIN_DEFAULT = 4'h2; // [R8]
    localparam logic [3:0] DETACH_PIN_DEFAULT = 4'h3;
    localparam logic [3:0] WAKE_PIN_DEFAULT = 4'h4;
    localparam logic [3:0] PULLUP_PIN_DEFAULT = 4'h5;
    localparam int SYNC_STAGES = 2;
    localparam int CLOCK_MHZ = 125;
    localparam int FS_RATE_KBPS = 12000;
    localparam int FS_BIT_CYCLES_X12 = CLOCK_MHZ;
    localparam int RECONNECT_US = 1;
    localparam int RECONNECT_CYCLES = (RECONNECT_US * CLOCK_MHZ < 1) ? 1 : RECONNECT_US * CLOCK_MHZ;

    // ****************************************
    // carrier types
    // ****************************************
    typedef struct packed {
        logic hci_build;
        logic self_powered;
        logic bus_powered;
        logic external_pullup;
        logic ready;
        logic wake_request;
        logic [3:0] vbus_pin;
        logic [3:0] detach_pin;
        logic [3:0] wake_pin;
        logic [3:0] pullup_pin;
    } uadc_config_t;

    typedef struct packed {
        logic attached;
        logic detached;
        logic vbus_present;
        logic inband_resume_ok;
        logic power_negotiate;
    } uadc_status_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_DETACHED = 4'b0010,
        ST_SETTLE = 4'b0100,
        ST_ATTACHED = 4'b1000
    } uadc_state_t;

endpackage

// file: rtl/uadc_sync.sv
// two-stage synchroniser for one level
`timescale 1ns/100ps
`default_nettype none
module uadc_sync
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // level in and out
    input wire logic d,
    output logic q
);
    logic meta;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            meta <= 1'b0;
            q <= 1'b0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // uadc_sync
`default_nettype wire

// file: rtl/uadc_control.sv
// usb attach and detach control: pull-up, vbus sense, detach and wake
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// [R1] full-speed function at 12 Mbit/s, driving the cable directly through the transceiver enables
// [R2] peripheral only; data lines driven only when attached, never host role
// [R3] usb port active only while the hci firmware build is selected
// [R4] pull-up enabled only once ready to enumerate
// [R5] internal pull-up by default, optional external pull-up on a chosen pin
// [R6] self-powered mode watches the vbus sense pin
// [R7] self-powered mode keeps pull-up off while vbus is absent
// [R8] vbus sense defaults to general purpose pin two
// [R9] bus-powered mode flags power negotiation during enumeration
// [R10] detach input and wake output map to any general purpose pin
// [R11] detach high tri-states both data lines and drops the pull-up
// [R12] detach low reconnects the pull-up and awaits enumeration
// [R13] wake output driven high only while detach is active
// [R14] no in-band resume while disconnected
// [R15] settles on full speed with usb 2.0 hosts
// [R16] detach and vbus inputs pass a two-stage synchroniser
module uadc_control
#(
    parameter int PINS = uadc_pkg::PIN_COUNT,
    parameter int SETTLE_CYCLES = uadc_pkg::RECONNECT_CYCLES
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // configuration from firmware
    input wire uadc_pkg::uadc_config_t cfg,
    // general purpose pins
    input wire logic [PINS-1:0] general_purpose_pin_in,
    output logic [PINS-1:0] general_purpose_pin_out,
    output logic [PINS-1:0] general_purpose_pin_oe_n,
    // usb core side transmit request
    input wire logic core_tx_en,
    input wire logic core_dp,
    input wire logic core_dn,
    // usb data lines
    output logic positive_data_line_out,
    output logic positive_data_line_oe_n,
    output logic negative_data_line_out,
    output logic negative_data_line_oe_n,
    output logic internal_pullup_en,
    // status
    output uadc_pkg::uadc_status_t status
);

    // ****************************************
    // input selection and synchronisers
    // ****************************************
    logic raw_vbus;
    logic raw_detach;
    logic vbus_sync;
    logic detach_sync;

    assign raw_vbus = general_purpose_pin_in[cfg.vbus_pin]; // [R6] [R8]
    assign raw_detach = general_purpose_pin_in[cfg.detach_pin]; // [R10]

    uadc_sync u_sync_vbus
    (
        .clock(clock),
        .rst(rst),
        .d(raw_vbus),
        .q(vbus_sync) // [R16]
    );

    uadc_sync u_sync_detach
    (
        .clock(clock),
        .rst(rst),
        .d(raw_detach),
        .q(detach_sync) // [R16]
    );

    // ****************************************
    // attach state machine
    // ****************************************
    uadc_pkg::uadc_state_t state;
    uadc_pkg::uadc_state_t next_state;
    logic [15:0] settle_count;
    logic port_enabled;
    logic power_ok;
    logic may_attach;

    assign port_enabled = cfg.hci_build; // [R3]
    assign power_ok = !cfg.self_powered || vbus_sync; // [R7]
    assign may_attach = port_enabled && power_ok && cfg.ready; // [R4]

    always_comb
    begin
        next_state = state;
        case (state)
            uadc_pkg::ST_IDLE:
            begin
                if (port_enabled && detach_sync)
                    next_state = uadc_pkg::ST_DETACHED; // [R11]
                else if (may_attach)
                    next_state = uadc_pkg::ST_SETTLE;
            end
            uadc_pkg::ST_DETACHED:
            begin
                if (!port_enabled)
                    next_state = uadc_pkg::ST_IDLE;
                else if (!detach_sync)
                    next_state = uadc_pkg::ST_SETTLE; // [R12]
            end
            uadc_pkg::ST_SETTLE:
            begin
                if (!port_enabled || !may_attach)
                    next_state = uadc_pkg::ST_IDLE;
                else if (detach_sync)
                    next_state = uadc_pkg::ST_DETACHED;
                else if (settle_count == 16'h0000)
                    next_state = uadc_pkg::ST_ATTACHED;
            end
            uadc_pkg::ST_ATTACHED:
            begin
                if (detach_sync && port_enabled)
                    next_state = uadc_pkg::ST_DETACHED; // [R11]
                else if (!may_attach)
                    next_state = uadc_pkg::ST_IDLE; // [R7]
            end
            default:
                next_state = uadc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            state <= uadc_pkg::ST_IDLE;
        else
            state <= next_state;
    end

    // settle delay before pull-up after reconnect
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            settle_count <= 16'h0000;
        else if (next_state == uadc_pkg::ST_SETTLE && state != uadc_pkg::ST_SETTLE)
            settle_count <= 16'(SETTLE_CYCLES - 1);
        else if (settle_count != 16'h0000)
            settle_count <= settle_count - 16'h0001;
    end

    // ****************************************
    // data lines and pull-up
    // ****************************************
    logic attached_next;
    logic drive_next;

    assign attached_next = (next_state == uadc_pkg::ST_ATTACHED);
    assign drive_next = attached_next && core_tx_en; // [R2]

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            positive_data_line_out <= 1'b0;
            negative_data_line_out <= 1'b0;
            positive_data_line_oe_n <= 1'b1;
            negative_data_line_oe_n <= 1'b1;
        end
        else
        begin
            positive_data_line_out <= drive_next & core_dp; // [R1]
            negative_data_line_out <= drive_next & core_dn; // [R1]
            positive_data_line_oe_n <= !drive_next; // [R11]
            negative_data_line_oe_n <= !drive_next; // [R11]
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            internal_pullup_en <= 1'b0;
        else
            internal_pullup_en <= attached_next && !cfg.external_pullup; // [R5] [R4] [R15]
    end

    // ****************************************
    // general purpose pin outputs
    // ****************************************
    logic wake_next;

    assign wake_next = (next_state == uadc_pkg::ST_DETACHED) && cfg.wake_request; // [R13]

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            general_purpose_pin_out <= '0;
            general_purpose_pin_oe_n <= '1;
        end
        else
        begin
            for (int i = 0; i < PINS; i++)
            begin
                general_purpose_pin_out[i] <= 1'b0;
                general_purpose_pin_oe_n[i] <= 1'b1;
                if (port_enabled && i == int'(cfg.wake_pin))
                begin
                    general_purpose_pin_out[i] <= wake_next; // [R10] [R13]
                    general_purpose_pin_oe_n[i] <= 1'b0;
                end
                if (port_enabled && cfg.external_pullup && i == int'(cfg.pullup_pin))
                begin
                    general_purpose_pin_out[i] <= attached_next; // [R5]
                    general_purpose_pin_oe_n[i] <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // status
    // ****************************************
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            status <= '0;
        else
        begin
            status.attached <= attached_next;
            status.detached <= (next_state == uadc_pkg::ST_DETACHED);
            status.vbus_present <= vbus_sync;
            status.inband_resume_ok <= attached_next; // [R14]
            status.power_negotiate <= attached_next && cfg.bus_powered && !cfg.self_powered; // [R9]
        end
    end

    // full speed only; a usb 2.0 host falls back to it through the pull-up on the positive line [R15]

    // ****************************************
    // assertions
    // ****************************************
    sequence s_detach_seen;
        detach_sync && port_enabled;
    endsequence

    a_detach_tristate: assert property (@(posedge clock) disable iff (rst) // [R11]
        s_detach_seen |=> positive_data_line_oe_n && negative_data_line_oe_n && !internal_pullup_en)
        else $error("data lines not released on detach");

    a_wake_only_detach: assert property (@(posedge clock) disable iff (rst) // [R13]
        general_purpose_pin_out[cfg.wake_pin] && !(cfg.external_pullup && cfg.wake_pin == cfg.pullup_pin)
        |-> status.detached)
        else $error("wake driven while attached");

    a_vbus_pullup_off: assert property (@(posedge clock) disable iff (rst) // [R7]
        cfg.self_powered && !vbus_sync |=> !internal_pullup_en)
        else $error("pull-up on without vbus");

    a_port_disabled: assert property (@(posedge clock) disable iff (rst) // [R3]
        !cfg.hci_build |=> !status.attached && positive_data_line_oe_n)
        else $error("usb active outside hci build");

    // reconnect: settle count, then pull-up back unless attach is withdrawn
    localparam int RECONNECT_LIMIT = SETTLE_CYCLES + 2;

    sequence s_reconnect_start;
        $fell(status.detached) && !detach_sync && may_attach && !cfg.external_pullup;
    endsequence

    sequence s_pullup_back;
        ##[0:RECONNECT_LIMIT] (internal_pullup_en || !may_attach || detach_sync);
    endsequence

    a_reconnect_pullup: assert property (@(posedge clock) disable iff (rst) // [R12]
        s_reconnect_start |-> s_pullup_back)
        else $error("pull-up not restored after detach");

    a_ready_gate: assert property (@(posedge clock) disable iff (rst) // [R4]
        !cfg.ready |=> !internal_pullup_en)
        else $error("pull-up before ready");

    a_no_resume_detached: assert property (@(posedge clock) disable iff (rst) // [R14]
        status.detached |-> !status.inband_resume_ok)
        else $error("in-band resume while detached");

    a_sync_delay: assert property (@(posedge clock) disable iff (rst) // [R16]
        detach_sync |-> $past(raw_detach, 2))
        else $error("detach not two-stage synchronised");

    a_ext_pullup: assert property (@(posedge clock) disable iff (rst) // [R5]
        cfg.external_pullup |=> !internal_pullup_en)
        else $error("internal pull-up on in external mode");

    a_wake_follows: assert property (@(posedge clock) disable iff (rst) // [R13]
        $stable(cfg) && status.detached && cfg.wake_request && cfg.hci_build
        && !(cfg.external_pullup && cfg.wake_pin == cfg.pullup_pin)
        |-> general_purpose_pin_out[cfg.wake_pin] && !general_purpose_pin_oe_n[cfg.wake_pin])
        else $error("wake not driven while detached");

    a_pin_released: assert property (@(posedge clock) disable iff (rst) // [R3]
        !cfg.hci_build |=> general_purpose_pin_oe_n == '1)
        else $error("pins driven outside hci build");

    a_drive_attached: assert property (@(posedge clock) disable iff (rst) // [R2]
        !positive_data_line_oe_n || !negative_data_line_oe_n |-> status.attached)
        else $error("data lines driven while not attached");

    a_power_attached: assert property (@(posedge clock) disable iff (rst) // [R9]
        status.power_negotiate |-> status.attached && status.inband_resume_ok)
        else $error("power negotiation outside enumeration");

endmodule // uadc_control
`default_nettype wire

// file: testbench/uadc_host_model.sv
// behavioural usb host port seen through the positive and negative data lines
`timescale 1ns/100ps
`default_nettype none
module uadc_host_model
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // device side of the data lines
    input wire logic dp_out,
    input wire logic dp_oe_n,
    input wire logic dn_out,
    input wire logic dn_oe_n,
    input wire logic internal_pullup,
    input wire logic external_pullup,
    // host view
    output logic dp_level,
    output logic full_speed
);
    logic dn_level;
    // host pull-downs win whenever the device releases a line and no pull-up is on
    assign dp_level = !dp_oe_n ? dp_out : (internal_pullup || external_pullup);
    assign dn_level = !dn_oe_n ? dn_out : 1'b0;
    // host only listens and never drives the lines itself
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            full_speed <= 1'b0;
        else
            full_speed <= dp_level && !dn_level;
    end
endmodule // uadc_host_model
`default_nettype wire

// file: testbench/uadc_control_bench.sv
// self-checking bench for the usb attach and detach control
`timescale 1ns/100ps
`default_nettype none
module uadc_control_bench;
    localparam int SETTLE = 4;
    logic clock = 1'b0;
    logic rst = 1'b1;
    uadc_pkg::uadc_config_t cfg;
    uadc_pkg::uadc_config_t c;
    uadc_pkg::uadc_status_t status;
    logic [15:0] gp_in;
    logic [15:0] gp_out;
    logic [15:0] gp_oe_n;
    logic tx_en;
    logic tx_dp;
    logic tx_dn;
    logic dp_out;
    logic dp_oe_n;
    logic dn_out;
    logic dn_oe_n;
    logic pu_en;
    logic host_dp;
    logic host_fs;
    int err_total = 0;
    int tests_run = 0;
    always #4 clock = ~clock;
    uadc_control #(.PINS(16), .SETTLE_CYCLES(SETTLE)) i_dut (.clock(clock), .rst(rst), .cfg(cfg),
        .general_purpose_pin_in(gp_in), .general_purpose_pin_out(gp_out), .general_purpose_pin_oe_n(gp_oe_n),
        .core_tx_en(tx_en), .core_dp(tx_dp), .core_dn(tx_dn), .positive_data_line_out(dp_out),
        .positive_data_line_oe_n(dp_oe_n), .negative_data_line_out(dn_out), .negative_data_line_oe_n(dn_oe_n),
        .internal_pullup_en(pu_en), .status(status));
    uadc_host_model i_host (.clock(clock), .rst(rst), .dp_out(dp_out), .dp_oe_n(dp_oe_n), .dn_out(dn_out),
        .dn_oe_n(dn_oe_n), .internal_pullup(pu_en), .external_pullup(gp_out[cfg.pullup_pin] && !gp_oe_n[cfg.pullup_pin]),
        .dp_level(host_dp), .full_speed(host_fs));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic apply;
        @(posedge clock);
        cfg <= c;
        tick(1);
    endtask
    task automatic set_pin(input int idx, input logic v);
        @(posedge clock);
        gp_in[idx] <= v;
        tick(1);
    endtask
    task automatic wait_attached;
        int k;
        k = 0;
        while (status.attached !== 1'b1 && k < 40)
        begin
            tick(1);
            k++;
        end
        check(status.attached, 1'b1);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_enable;
        c = cfg;
        c.ready = 1'b1;
        apply();
        tick(20);
        check({pu_en, status.attached}, 2'b00);
        check(gp_oe_n, 16'hffff);
        c.hci_build = 1'b1;
        c.ready = 1'b0;
        apply();
        tick(20);
        check(pu_en, 1'b0);
        c.ready = 1'b1;
        apply();
        wait_attached();
        tick(2);
        check(pu_en, 1'b1);
        check(host_fs, 1'b1);
        check(status.inband_resume_ok, 1'b1);
    endtask
    task automatic t_drive;
        @(posedge clock);
        tx_en <= 1'b1;
        tx_dp <= 1'b1;
        tick(3);
        check({dp_oe_n, dn_oe_n, dp_out, dn_out}, 4'b0010);
        c.bus_powered = 1'b1;
        apply();
        tick(3);
        check(status.power_negotiate, 1'b1);
    endtask
    task automatic t_vbus;
        c.bus_powered = 1'b0;
        c.self_powered = 1'b1;
        apply();
        tick(6);
        check({pu_en, status.vbus_present}, 2'b00);
        set_pin(2, 1'b1);
        tick(4);
        wait_attached();
        check({pu_en, status.vbus_present, status.power_negotiate}, 3'b110);
    endtask
    task automatic t_detach(input int det, input int wk);
        c.wake_request = 1'b1;
        apply();
        set_pin(det, 1'b1);
        tick(4);
        check({dp_oe_n, dn_oe_n, pu_en}, 3'b110);
        check({host_dp, gp_out[5]}, 2'b00);
        check({status.detached, status.inband_resume_ok}, 2'b10);
        check({gp_out[wk], gp_oe_n[wk]}, 2'b10);
        set_pin(det, 1'b0);
        tick(4);
        check(gp_out[wk], 1'b0);
        wait_attached();
        check(dp_oe_n, !tx_en);
    endtask
    task automatic t_remap;
        c.detach_pin = 4'h9;
        c.wake_pin = 4'ha;
        c.external_pullup = 1'b1;
        @(posedge clock);
        tx_en <= 1'b0;
        apply();
        tick(6);
        check({pu_en, gp_out[5], gp_oe_n[5]}, 3'b010);
        check(host_fs, 1'b1);
        check(gp_oe_n[4], 1'b1);
        t_detach(9, 10);
        check({gp_out[5], gp_oe_n[5]}, 2'b10);
    endtask
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial
    begin
        cfg = '0;
        cfg.vbus_pin = uadc_pkg::VBUS_PIN_DEFAULT;
        cfg.detach_pin = uadc_pkg::DETACH_PIN_DEFAULT;
        cfg.wake_pin = uadc_pkg::WAKE_PIN_DEFAULT;
        cfg.pullup_pin = uadc_pkg::PULLUP_PIN_DEFAULT;
        gp_in = 16'h0000;
        tx_en = 1'b0;
        tx_dp = 1'b0;
        tx_dn = 1'b0;
        tick(3);
        check({dp_oe_n, dn_oe_n, pu_en, status}, 8'hc0);
        check(gp_oe_n, 16'hffff);
        @(posedge clock);
        rst <= 1'b0;
        t_enable();
        t_drive();
        t_vbus();
        t_detach(3, 4);
        t_remap();
        finish_test();
    end
    initial
    begin
        repeat (5000) @(posedge clock);
        err_total++;
        finish_test();
    end
endmodule // uadc_control_bench
`default_nettype wire
